// ===== logic/usfc_top.sv
// serial port control, frame format, baud generator and frame engines behind APB
//
// The placing of the registers and register access over APB are this design's own decisions.
module usfc_top
    import usfc_pkg::*;
(
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic [7:0] paddr, // byte address
    input wire logic psel, // slave select
    input wire logic penable, // access phase
    input wire logic pwrite, // write when high
    input wire logic [31:0] pwdata, // write data
    output logic [31:0] prdata, // read data
    output logic pready, // transfer done
    output logic pslverr, // unmapped address
    input wire logic receive_pin, // serial data in
    output logic transmit_pin, // serial data out
    output logic transmit_pin_oe, // transmitter owns the pin
    output logic receive_pin_own, // receiver owns the pin
    output logic sync_transfer_clock, // generated transfer clock
    output logic sync_transfer_clock_oe // clock driven in sync modes
);
    // *****************************************
    // registers and bus
    // *****************************************
    logic [7:0] ctrl_b_reg, ctrl_b_next;
    logic [7:0] frame_c_reg, frame_c_next;
    logic [11:0] baud_reg, baud_next;
    logic dbl_reg, dbl_next;
    logic txc_reg, txc_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic [31:0] prdata_reg, prdata_next;
    logic [8:0] txbuf_reg, txbuf_next;
    logic txfull_reg, txfull_next;
    logic [8:0] rxbuf_reg;
    logic rxfull_reg, fe_reg, pe_reg, dor_reg;
    logic acc, wr, rd, mapped, tx_done, tx_load;
    logic [3:0] nbits;
    logic sync_m, par_en, par_odd;
    always_comb
    begin
        acc = psel & penable & pready_reg;
        wr = acc & pwrite;
        rd = acc & ~pwrite;
        mapped = paddr inside {OFF_CTRL_B, OFF_FRAME_C, OFF_BAUD_LO, OFF_BAUD_HI,
            OFF_STATUS, OFF_DATA};
        nbits = usfc_nbits({ctrl_b_reg[B_CSZ2], frame_c_reg[C_CSZ_HI:C_CSZ_LO]});
        sync_m = frame_c_reg[C_MODE_SYNC];
        par_en = frame_c_reg[C_PAR_EN];
        par_odd = frame_c_reg[C_PAR_ODD];
        ctrl_b_next = ctrl_b_reg;
        frame_c_next = frame_c_reg;
        baud_next = baud_reg;
        dbl_next = dbl_reg;
        txbuf_next = txbuf_reg;
        txfull_next = txfull_reg;
        txc_next = txc_reg;
        pready_next = psel & penable & ~pready_reg;
        pslverr_next = psel & penable & ~pready_reg & ~mapped;
        prdata_next = 32'h0000_0000;
        if (psel & penable & ~pready_reg)
        begin
            unique case (paddr)
                OFF_CTRL_B: prdata_next[7:0] = {ctrl_b_reg[7:2], rxbuf_reg[8],
                    ctrl_b_reg[B_TX9]};
                OFF_FRAME_C: prdata_next[7:0] = frame_c_reg;
                OFF_BAUD_LO: prdata_next[7:0] = baud_reg[7:0];
                OFF_BAUD_HI: prdata_next[3:0] = baud_reg[11:8];
                OFF_STATUS: prdata_next[7:0] = {rxfull_reg, txc_reg, ~txfull_reg,
                    fe_reg, dor_reg, pe_reg, dbl_reg, 1'b0};
                OFF_DATA: prdata_next[7:0] = rxbuf_reg[7:0];
                default: prdata_next = 32'h0000_0000;
            endcase
        end
        if (wr)
        begin
            unique case (paddr)
                OFF_CTRL_B: ctrl_b_next = {pwdata[7:2], 1'b0, pwdata[0]};
                OFF_FRAME_C: frame_c_next = pwdata[7:0];
                OFF_BAUD_LO: baud_next[7:0] = pwdata[7:0];
                OFF_BAUD_HI: baud_next[11:8] = pwdata[3:0];
                OFF_STATUS:
                begin
                    dbl_next = pwdata[S_DBL];
                    if (pwdata[S_TXC])
                        txc_next = 1'b0;
                end
                OFF_DATA:
                    if (!txfull_reg)
                    begin
                        // ninth bit is taken from the control register now
                        txbuf_next = {ctrl_b_reg[B_TX9], pwdata[7:0]};
                        txfull_next = 1'b1;
                    end
                default: ;
            endcase
        end
        if (tx_load)
            txfull_next = 1'b0;
        if (tx_done & ~txfull_next)
            txc_next = 1'b1;
    end
    // *****************************************
    // baud prescaler and bit timing
    // *****************************************
    logic [11:0] bcnt_reg, bcnt_next;
    logic [3:0] txos_reg, txos_next;
    logic xck_reg, xck_next;
    logic tick, tx_step, rx_edge;
    logic [3:0] os_top, os_mid;
    always_comb
    begin
        // a low-byte write restarts the count at once, even mid-frame
        tick = (bcnt_reg == 12'h000);
        bcnt_next = tick ? baud_reg : 12'(bcnt_reg - 12'h001);
        if (wr && paddr == OFF_BAUD_LO)
            bcnt_next = {baud_reg[11:8], pwdata[7:0]};
        os_top = (dbl_reg & ~sync_m) ? OS_TOP_D : OS_TOP_N;
        os_mid = (dbl_reg & ~sync_m) ? OS_MID_D : OS_MID_N;
        txos_next = txos_reg;
        if (tick)
            txos_next = (txos_reg >= os_top) ? 4'h0 : 4'(txos_reg + 4'h1);
        xck_next = sync_m ? (xck_reg ^ tick) : 1'b0;
        if (sync_m)
        begin
            tx_step = tick & (xck_reg == frame_c_reg[C_POL]);
            rx_edge = tick & (xck_reg != frame_c_reg[C_POL]);
        end
        else
        begin
            // a count left above the top by a speed change wraps first, no short bit
            tx_step = tick & (txos_reg == os_top);
            rx_edge = tick;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_b_reg <= CTRL_B_RST;
            frame_c_reg <= FRAME_C_RST;
            baud_reg <= BAUD_RST;
            dbl_reg <= 1'b0;
            txc_reg <= 1'b0;
            txbuf_reg <= 9'h000;
            txfull_reg <= 1'b0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            bcnt_reg <= BAUD_RST;
            txos_reg <= 4'h0;
            xck_reg <= 1'b0;
        end
        else
        begin
            ctrl_b_reg <= ctrl_b_next;
            frame_c_reg <= frame_c_next;
            baud_reg <= baud_next;
            dbl_reg <= dbl_next;
            txc_reg <= txc_next;
            txbuf_reg <= txbuf_next;
            txfull_reg <= txfull_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
            bcnt_reg <= bcnt_next;
            txos_reg <= txos_next;
            xck_reg <= xck_next;
        end
    end
    // *****************************************
    // transmitter
    // *****************************************
    usfc_tx_t tx_reg, tx_next;
    logic [8:0] tsh_reg, tsh_next;
    logic [3:0] tcnt_reg, tcnt_next;
    logic tpar_reg, tpar_next;
    logic txd_reg, txd_next;
    logic toe_reg, toe_next;
    logic [8:0] tdat;
    always_comb
    begin
        tx_next = tx_reg;
        tsh_next = tsh_reg;
        tcnt_next = tcnt_reg;
        tpar_next = tpar_reg;
        txd_next = txd_reg;
        tx_done = 1'b0;
        tdat = txbuf_reg & usfc_mask(nbits);
        tx_load = tx_step & (tx_reg == TX_IDLE) & txfull_reg;
        if (tx_step)
        begin
            unique case (tx_reg)
                TX_IDLE:
                    if (txfull_reg)
                    begin
                        tsh_next = tdat;
                        tpar_next = (^tdat) ^ par_odd;
                        tcnt_next = 4'h1;
                        tx_next = TX_START;
                        txd_next = 1'b0;
                    end
                TX_START:
                begin
                    tx_next = TX_DATA;
                    txd_next = tsh_reg[0];
                end
                TX_DATA:
                    if (tcnt_reg == nbits)
                    begin
                        tx_next = par_en ? TX_PAR : TX_STOP1;
                        txd_next = par_en ? tpar_reg : 1'b1;
                    end
                    else
                    begin
                        tsh_next = tsh_reg >> 1;
                        tcnt_next = 4'(tcnt_reg + 4'h1);
                        txd_next = tsh_reg[1];
                    end
                TX_PAR:
                begin
                    tx_next = TX_STOP1;
                    txd_next = 1'b1;
                end
                TX_STOP1:
                begin
                    tx_next = frame_c_reg[C_STOP] ? TX_STOP2 : TX_IDLE;
                    tx_done = ~frame_c_reg[C_STOP];
                end
                TX_STOP2:
                begin
                    tx_next = TX_IDLE;
                    tx_done = 1'b1;
                end
                default:
                    tx_next = TX_IDLE;
            endcase
        end
        // pending work keeps the pin after enable drops
        toe_next = ctrl_b_reg[B_TXEN] | (tx_next != TX_IDLE) | txfull_next;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_reg <= TX_IDLE;
            tsh_reg <= 9'h000;
            tcnt_reg <= 4'h0;
            tpar_reg <= 1'b0;
            txd_reg <= 1'b1;
            toe_reg <= 1'b0;
        end
        else
        begin
            tx_reg <= toe_reg ? tx_next : TX_IDLE;
            tsh_reg <= tsh_next;
            tcnt_reg <= tcnt_next;
            tpar_reg <= tpar_next;
            txd_reg <= toe_reg ? txd_next : 1'b1;
            toe_reg <= toe_next;
        end
    end
    // *****************************************
    // receiver
    // *****************************************
    usfc_rx_t rx_reg, rx_next;
    logic [8:0] rsh_reg, rsh_next, rxbuf_next, rdat;
    logic [3:0] rcnt_reg, rcnt_next, ros_reg, ros_next;
    logic rpar_reg, rpar_next, rxfull_next, fe_next, pe_next, dor_next;
    logic ren_reg, ren_next, rsamp, rd_data;
    always_comb
    begin
        rx_next = rx_reg;
        rsh_next = rsh_reg;
        rcnt_next = rcnt_reg;
        rpar_next = rpar_reg;
        ros_next = ros_reg;
        rxbuf_next = rxbuf_reg;
        rxfull_next = rxfull_reg;
        fe_next = fe_reg;
        pe_next = pe_reg;
        dor_next = dor_reg;
        ren_next = ctrl_b_reg[B_RXEN];
        rdat = 9'(rsh_reg >> (4'h9 - nbits));
        rd_data = rd && paddr == OFF_DATA;
        if (rd_data)
        begin
            rxfull_next = 1'b0;
            fe_next = 1'b0;
            pe_next = 1'b0;
            dor_next = 1'b0;
        end
        if (rx_edge && !sync_m)
            ros_next = (ros_reg >= os_top) ? 4'h0 : 4'(ros_reg + 4'h1);
        rsamp = sync_m ? rx_edge :
            rx_edge & (ros_reg == ((rx_reg == RX_START) ? os_mid : os_top));
        if (rx_reg == RX_IDLE)
        begin
            ros_next = 4'h0;
            if (ren_reg && rx_edge && !receive_pin)
                rx_next = sync_m ? RX_DATA : RX_START;
            rcnt_next = 4'h0;
        end
        else if (rsamp)
        begin
            ros_next = 4'h0;
            unique case (rx_reg)
                RX_START:
                    rx_next = receive_pin ? RX_IDLE : RX_DATA;
                RX_DATA:
                begin
                    rsh_next = {receive_pin, rsh_reg[8:1]};
                    rcnt_next = 4'(rcnt_reg + 4'h1);
                    if (4'(rcnt_reg + 4'h1) == nbits)
                        rx_next = par_en ? RX_PAR : RX_STOP;
                end
                RX_PAR:
                begin
                    rpar_next = receive_pin;
                    rx_next = RX_STOP;
                end
                RX_STOP:
                begin
                    // only the first stop bit is checked, whatever the stop select
                    rx_next = RX_IDLE;
                    if (rxfull_reg && !rd_data)
                        dor_next = 1'b1;
                    else
                    begin
                        rxbuf_next = rdat;
                        rxfull_next = 1'b1;
                        fe_next = ~receive_pin;
                        pe_next = par_en & ((^rdat) ^ par_odd ^ rpar_reg);
                    end
                end
                default:
                    rx_next = RX_IDLE;
            endcase
        end
        if (!ren_reg)
        begin
            rx_next = RX_IDLE;
            rxfull_next = 1'b0;
            fe_next = 1'b0;
            pe_next = 1'b0;
            dor_next = 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_reg <= RX_IDLE;
            rsh_reg <= 9'h000;
            rcnt_reg <= 4'h0;
            rpar_reg <= 1'b0;
            ros_reg <= 4'h0;
            rxbuf_reg <= 9'h000;
            rxfull_reg <= 1'b0;
            fe_reg <= 1'b0;
            pe_reg <= 1'b0;
            dor_reg <= 1'b0;
            ren_reg <= 1'b0;
        end
        else
        begin
            rx_reg <= rx_next;
            rsh_reg <= rsh_next;
            rcnt_reg <= rcnt_next;
            rpar_reg <= rpar_next;
            ros_reg <= ros_next;
            rxbuf_reg <= rxbuf_next;
            rxfull_reg <= rxfull_next;
            fe_reg <= fe_next;
            pe_reg <= pe_next;
            dor_reg <= dor_next;
            ren_reg <= ren_next;
        end
    end
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign transmit_pin = txd_reg;
    assign transmit_pin_oe = toe_reg;
    assign receive_pin_own = ren_reg;
    assign sync_transfer_clock = xck_reg;
    assign sync_transfer_clock_oe = sync_m;
    // *****************************************
    // checks
    // *****************************************
    property p_rx_own;
        @(posedge pclk) disable iff (!presetn) ctrl_b_reg[B_RXEN] |=> receive_pin_own;
    endproperty
    a_rx_own: assert property (p_rx_own) else $error("receiver did not take pin");
    property p_flush;
        @(posedge pclk) disable iff (!presetn)
            !ren_reg |=> !rxfull_reg && !fe_reg && !pe_reg && !dor_reg;
    endproperty
    a_flush: assert property (p_flush) else $error("flags kept while disabled");
    property p_tx_own;
        @(posedge pclk) disable iff (!presetn) ctrl_b_reg[B_TXEN] |=> transmit_pin_oe;
    endproperty
    a_tx_own: assert property (p_tx_own) else $error("transmitter did not take pin");
    property p_tx_hold;
        @(posedge pclk) disable iff (!presetn)
            (tx_reg != TX_IDLE || txfull_reg) |-> transmit_pin_oe;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("pin released early");
    property p_baud_lo;
        @(posedge pclk) disable iff (!presetn)
            wr && paddr == OFF_BAUD_LO |=> bcnt_reg == baud_reg;
    endproperty
    a_baud_lo: assert property (p_baud_lo) else $error("prescaler not reloaded");
    property p_hi_rsv;
        @(posedge pclk) disable iff (!presetn)
            psel && penable && !pready_reg && !pwrite && paddr == OFF_BAUD_HI
            |=> prdata[31:4] == 28'h0000000;
    endproperty
    a_hi_rsv: assert property (p_hi_rsv) else $error("reserved baud bits not zero");
    property p_par_bit;
        @(posedge pclk) disable iff (!presetn)
            $rose(tx_reg == TX_PAR) |-> transmit_pin == tpar_reg;
    endproperty
    a_par_bit: assert property (p_par_bit) else $error("wrong parity bit sent");
    property p_one_stop;
        @(posedge pclk) disable iff (!presetn)
            tx_step && tx_reg == TX_STOP1 && !frame_c_reg[C_STOP] && toe_reg
            |=> tx_reg == TX_IDLE;
    endproperty
    a_one_stop: assert property (p_one_stop) else $error("extra stop bit");
    property p_async_step;
        @(posedge pclk) disable iff (!presetn)
            !sync_m && tx_step |-> txos_reg == os_top && tick;
    endproperty
    a_async_step: assert property (p_async_step) else $error("bad bit period");
endmodule : usfc_top

// ===== pkg/usfc_pkg.sv
// constants, types and decode helpers for the serial frame and baud control block
// Summary of operation
// - receive-enable on starts the receiver and takes over the receive pin.
// - receive-enable off empties the receive buffer and its error flags.
// - transmit-enable on starts the transmitter and takes over the transmit pin.
// - after transmit-enable off, finish buffer and shifter, then release the pin.
// - mode field: 00 async, 01 sync, 11 master SPI, 10 reserved; only bit 6 is decoded, so 11 runs as sync and 10 as async.
// - parity field: 00 off, 10 even, 11 odd; transmitter appends parity.
// - receiver checks parity of each character and flags a mismatch.
// - stop select gives one or two transmitted stop bits; receiver ignores it.
// - size codes 000..011 give 5..8 bits, 111 gives 9; others reserved.
// - sync polarity 0: transmit on rising, sample on falling; 1 reverses.
// - baud value is 12 bits: high register bits 11..8, low bits 7..0.
// - writing the low baud byte reloads the prescaler at once.
// - low-byte baud writes act immediately, even mid-frame, possibly corrupting it; high-byte writes wait for the next reload.
// - double speed cuts the async divider from sixteen to eight.
package usfc_pkg;
    // *****************************************
    // register map (byte addresses on APB)
    // *****************************************
    localparam logic [7:0] OFF_CTRL_B = 8'h00;
    localparam logic [7:0] OFF_FRAME_C = 8'h04;
    localparam logic [7:0] OFF_BAUD_LO = 8'h08;
    localparam logic [7:0] OFF_BAUD_HI = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_DATA = 8'h14;
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [7:0] FRAME_C_RST = 8'h06;
    localparam logic [11:0] BAUD_RST = 12'h000;
    // *****************************************
    // field positions
    // *****************************************
    localparam int B_RXEN = 4;
    localparam int B_TXEN = 3;
    localparam int B_CSZ2 = 2;
    localparam int B_RX9 = 1;
    localparam int B_TX9 = 0;
    localparam int C_STOP = 3;
    localparam int C_POL = 0;
    localparam int C_MODE_SYNC = 6;
    localparam int C_PAR_EN = 5;
    localparam int C_PAR_ODD = 4;
    localparam int C_CSZ_HI = 2;
    localparam int C_CSZ_LO = 1;
    localparam int S_RXFULL = 7;
    localparam int S_TXC = 6;
    localparam int S_TXEMPTY = 5;
    localparam int S_FE = 4;
    localparam int S_DOR = 3;
    localparam int S_PE = 2;
    localparam int S_DBL = 1;
    // *****************************************
    // oversampling: 16 ticks a bit, 8 at double speed
    // *****************************************
    localparam logic [3:0] OS_TOP_N = 4'hF;
    localparam logic [3:0] OS_TOP_D = 4'h7;
    localparam logic [3:0] OS_MID_N = 4'h7;
    localparam logic [3:0] OS_MID_D = 4'h3;
    typedef enum logic [1:0] {MODE_ASYNC = 2'b00, MODE_SYNC = 2'b01,
        MODE_RSVD = 2'b10, MODE_MSPI = 2'b11} usfc_mode_t;
    typedef enum logic [2:0] {TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b010,
        TX_PAR = 3'b011, TX_STOP1 = 3'b100, TX_STOP2 = 3'b101} usfc_tx_t;
    typedef enum logic [2:0] {RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b010,
        RX_PAR = 3'b011, RX_STOP = 3'b100} usfc_rx_t;
    // reserved size codes fall back to eight bits
    function automatic logic [3:0] usfc_nbits(input logic [2:0] c);
        case (c)
            3'b000: usfc_nbits = 4'h5;
            3'b001: usfc_nbits = 4'h6;
            3'b010: usfc_nbits = 4'h7;
            3'b111: usfc_nbits = 4'h9;
            default: usfc_nbits = 4'h8;
        endcase
    endfunction : usfc_nbits
    function automatic logic [8:0] usfc_mask(input logic [3:0] n);
        usfc_mask = 9'(~(9'h1FF << n));
    endfunction : usfc_mask
endpackage : usfc_pkg

// ===== bench/usfc_peer.sv
// remote serial peer: sends frames to the block and captures its frames
module usfc_peer
(
    input wire logic pclk, // system clock
    input wire logic transmit_pin, // line from the block
    output logic receive_pin // line to the block, idles high
);
    timeunit 1ns;
    timeprecision 1ps;
    initial receive_pin = 1'b1;
    // start bit, then n bits lsb first; the line is left at the stop level
    task send(input int per, input int n, input logic [15:0] b);
        for (int i = -1; i < n; i++)
        begin
            @(posedge pclk);
            receive_pin <= (i < 0) ? 1'b0 : b[i];
            repeat (per - 1) @(posedge pclk);
        end
        @(posedge pclk);
        receive_pin <= 1'b1;
    endtask : send
    // bounded wait for a start bit, then one sample in the middle of each bit
    task grab(input int per, input int n, output logic [15:0] b);
        int k;
        k = 0;
        b = 16'h0000;
        while (transmit_pin !== 1'b0 && k < 5000)
        begin
            @(posedge pclk);
            k++;
        end
        repeat (per / 2) @(posedge pclk);
        for (int i = 0; i < n; i++)
        begin
            repeat (per) @(posedge pclk);
            b[i] = transmit_pin;
        end
    endtask : grab
endmodule : usfc_peer

// ===== bench/usfc_top_tb.sv
// self-checking bench for the serial frame and baud control block
module usfc_top_tb
    import usfc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rv;
    logic pready, pslverr, err, receive_pin, transmit_pin, tx_oe, rx_own, clk_oe, xck;
    logic [15:0] bits;
    int failures = 0;
    int total_checks = 0;
    usfc_top usfc_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .receive_pin(receive_pin),
        .transmit_pin(transmit_pin), .transmit_pin_oe(tx_oe), .receive_pin_own(rx_own),
        .sync_transfer_clock(xck), .sync_transfer_clock_oe(clk_oe));
    usfc_peer usfc_peer_inst (.pclk(pclk), .transmit_pin(transmit_pin),
        .receive_pin(receive_pin));
    initial forever #10 pclk = ~pclk;
    // ****************************************
    // bus and compare helpers
    // ****************************************
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // entered just after a rising edge; ends one idle edge later
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20) failures++;
        rv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // poll the status register until a character is buffered
    task rx_wait();
        int n;
        n = 0;
        rv = 32'h0;
        while (rv[7] !== 1'b1 && n < 20)
        begin
            apb(1'b0, OFF_STATUS, 32'h0);
            n++;
        end
    endtask : rx_wait
    task rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rv);
    endtask : rdchk
    // ****************************************
    // scenarios
    // ****************************************
    task t_reset();
        rdchk("ctrl_b", OFF_CTRL_B, 32'h0);
        rdchk("frame_c", OFF_FRAME_C, 32'h06);
        rdchk("baud_lo", OFF_BAUD_LO, 32'h0);
        rdchk("status", OFF_STATUS, 32'h20);
        rdchk("unmapped", 8'h1C, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        chk("clk_oe", 32'h0, {31'h0, clk_oe});
    endtask : t_reset
    task t_setup();
        apb(1'b1, OFF_BAUD_HI, 32'hFF);
        rdchk("baud_hi", OFF_BAUD_HI, 32'h0F);
        apb(1'b1, OFF_BAUD_HI, 32'h00);
        apb(1'b1, OFF_BAUD_LO, 32'h01);
        apb(1'b1, OFF_CTRL_B, 32'h18);
        repeat (2) @(posedge pclk);
        chk("tx_oe", 32'h1, {31'h0, tx_oe});
        chk("rx_own", 32'h1, {31'h0, rx_own});
    endtask : t_setup
    // even parity, two stops, transmitter switched off right behind the data
    task t_tx_par();
        apb(1'b1, OFF_FRAME_C, 32'h2E);
        apb(1'b1, OFF_DATA, 32'hA5);
        apb(1'b1, OFF_CTRL_B, 32'h10);
        usfc_peer_inst.grab(32, 11, bits);
        chk("tx_frame", {21'h0, 2'b11, ^8'hA5, 8'hA5}, {16'h0, bits});
        chk("oe_busy", 32'h1, {31'h0, tx_oe});
        repeat (64) @(posedge pclk);
        chk("oe_done", 32'h0, {31'h0, tx_oe});
    endtask : t_tx_par
    task t_tx9();
        apb(1'b1, OFF_STATUS, 32'h02);
        apb(1'b1, OFF_FRAME_C, 32'h06);
        apb(1'b1, OFF_CTRL_B, 32'h0D);
        apb(1'b1, OFF_DATA, 32'h3C);
        usfc_peer_inst.grab(16, 10, bits);
        chk("tx9_frame", 32'h33C, {16'h0, bits});
        repeat (16) @(posedge pclk);
        apb(1'b1, OFF_STATUS, 32'h00);
    endtask : t_tx9
    // odd parity expected, peer sends the wrong parity bit
    task t_rx_par();
        apb(1'b1, OFF_FRAME_C, 32'h36);
        apb(1'b1, OFF_CTRL_B, 32'h10);
        usfc_peer_inst.send(32, 10, 16'h025A);
        rx_wait();
        // tx complete is still set from the last transmitted frame
        chk("rx_err", 32'hC4, rv & 32'hDC);
        apb(1'b1, OFF_STATUS, 32'h40);
        apb(1'b1, OFF_CTRL_B, 32'h00);
        rdchk("flushed", OFF_STATUS, 32'h20);
        chk("rx_own_off", 32'h0, {31'h0, rx_own});
        // nine-bit character with correct odd parity
        apb(1'b1, OFF_CTRL_B, 32'h14);
        usfc_peer_inst.send(32, 11, 16'h05A5);
        rx_wait();
        chk("rx_ok", 32'h80, rv & 32'h9C);
        rdchk("rx9", OFF_CTRL_B, 32'h16);
        rdchk("rx_data", OFF_DATA, 32'hA5);
        apb(1'b1, OFF_CTRL_B, 32'h00);
    endtask : t_rx_par
    // synchronous mode drives the transfer clock, toggling every baud period
    task t_sync();
        logic ck;
        apb(1'b1, OFF_FRAME_C, 32'h40);
        chk("clk_oe_sync", 32'h1, {31'h0, clk_oe});
        ck = xck;
        repeat (2) @(posedge pclk);
        chk("xck_toggle", {31'h0, ~ck}, {31'h0, xck});
        apb(1'b1, OFF_FRAME_C, 32'h06);
    endtask : t_sync
    task print_verdict();
        if (failures == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_setup();
        t_tx_par();
        t_tx9();
        t_rx_par();
        t_sync();
        print_verdict();
    end
    // the scenarios need a few thousand cycles at most
    initial
    begin
        repeat (20000) @(posedge pclk);
        failures++;
        print_verdict();
    end
endmodule : usfc_top_tb
